//--- rtl/lci_defines.vh
// Constants for the light curtain output and indicator block.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef LCI_DEFINES_VH
`define LCI_DEFINES_VH

// ****************************************
// Geometry
// ****************************************
`define LCI_NUM_CH 16
`define LCI_GRP_SIZE 4
`define LCI_NUM_SEG 4

// ****************************************
// Timing
// ****************************************
// 250 ms half period at the 40 MHz reference clock, sized for the 24-bit counter
`define LCI_BLINK_HALF_CYC 24'h989680

// ****************************************
// Register byte offsets
// ****************************************
`define LCI_OFS_CTRL 8'h00
`define LCI_OFS_STATUS 8'h04
`define LCI_OFS_IRQ_STAT 8'h08
`define LCI_OFS_IRQ_MASK 8'h0c
`define LCI_OFS_BEAMS 8'h10

// ****************************************
// Field positions
// ****************************************
`define LCI_CTRL_MUTE_EN 0
`define LCI_CTRL_FORCE_OFF 1
`define LCI_ST_SAFETY_ON 0
`define LCI_ST_ALL_CLEAR 1
`define LCI_ST_MUTED 2
`define LCI_ST_STABLE 3
`define LCI_IRQ_OFF 0
`define LCI_IRQ_ON 1
`define LCI_IRQ_UNSTABLE 2
`define LCI_IRQ_MUTE 3
`define LCI_IRQ_W 4

// ****************************************
// Reset values
// ****************************************
`define LCI_CTRL_RST 2'h0
`define LCI_IRQ_MASK_RST 4'h0

`endif

//--- rtl/lci_light_curtain.v
// Receiver-side decision and indicator logic of a safety light curtain.
// Assumes beam, muting, stability and indicator inputs synchronous to ref_clk,
// and a classic Wishbone master on the same clock.
`timescale 1ns/10ps
`include "lci_defines.vh"

// Summary of operation
// - Both safety outputs ON only when all beams clear or muting applies
// - Any interrupted beam turns both outputs OFF unless muting applies
// - Muting overrides the all-beams-clear decision
// - Red indicator input lights large lamp red
// - Green indicator input lights large lamp green
// - Indicator input off shows no colour
// - Stable light drives stability lamp green
// - Unstable light drives stability lamp orange
// - Blocked light path turns stability lamp off
// - Outputs ON light every alignment segment green
// - Top group receiving lights top segment red
// - Topmost channel receiving blinks top segment red
// - Upper middle group lights second segment red
// - Lower middle group lights third segment red
// - Bottom group receiving lights bottom segment red
// - Lowest channel receiving blinks bottom segment red
module lci_light_curtain #(
  parameter [23:0] BLINK_HALF_CYC = `LCI_BLINK_HALF_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,

  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,

  // Optical front end
  input wire [`LCI_NUM_CH-1:0] beam_rx,
  input wire light_stable,
  input wire muting_active,

  // Large indicator inputs
  input wire big_red_in,
  input wire big_green_in,

  // Safety outputs
  output reg safety_output_a,
  output reg safety_output_b,

  // Indicators
  output reg light_stability_lamp_green,
  output reg light_stability_lamp_orange,
  output reg [`LCI_NUM_SEG-1:0] beam_alignment_display_green,
  output reg [`LCI_NUM_SEG-1:0] beam_alignment_display_red,
  output reg big_lamp_red,
  output reg big_lamp_green,

  // Interrupt
  output reg irq
);

  // ****************************************
  // Group decoding
  // ****************************************

  // Whole group receiving light; group 0 is the bottom one
  function grp_full;
    input [`LCI_NUM_CH-1:0] beams;
    input integer grp;
    integer i;
    begin
      grp_full = 1'b1;
      for (i = 0; i < `LCI_GRP_SIZE; i = i + 1) begin
        if (!beams[grp * `LCI_GRP_SIZE + i]) begin
          grp_full = 1'b0;
        end
      end
    end
  endfunction

  // Any channel of a group receiving light
  function grp_any;
    input [`LCI_NUM_CH-1:0] beams;
    input integer grp;
    integer i;
    begin
      grp_any = 1'b0;
      for (i = 0; i < `LCI_GRP_SIZE; i = i + 1) begin
        if (beams[grp * `LCI_GRP_SIZE + i]) begin
          grp_any = 1'b1;
        end
      end
    end
  endfunction

  // Write strobe of one register; shared by every writable offset
  function wr_hit;
    input commit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      wr_hit = commit && (adr == ofs);
    end
  endfunction

  // ****************************************
  // Display geometry
  // ****************************************

  // Segment 0 is the bottom one; its end channel is channel 0
  localparam SEG_BOT = 0;
  localparam SEG_TOP = `LCI_NUM_SEG - 1;
  localparam CH_BOT = 0;
  localparam CH_TOP = `LCI_NUM_CH - 1;

  // ****************************************
  // Register file state
  // ****************************************

  reg [1:0] ctrl_q;
  reg [`LCI_IRQ_W-1:0] irq_stat_q;
  reg [`LCI_IRQ_W-1:0] irq_stat_d;
  reg [`LCI_IRQ_W-1:0] irq_mask_q;
  reg [31:0] rd_data_d;

  wire bus_req;
  wire wr_commit;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // The write lands on the edge where the master sees ack
  // Every writable field sits in byte 0, so sel bit 0 alone qualifies a write
  assign wr_commit = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];

  // ****************************************
  // Safety decision
  // ****************************************

  wire all_clear;
  wire muted;
  wire safety_d;
  reg safety_q;
  reg stable_q;
  reg muted_q;

  assign all_clear = &beam_rx;
  assign muted = muting_active & ctrl_q[`LCI_CTRL_MUTE_EN];
  // Force-off lets software hold the machine stopped, even over muting
  assign safety_d = (all_clear | muted) & ~ctrl_q[`LCI_CTRL_FORCE_OFF];

  // Two flops, so one stuck output shows as a disagreement to the machine
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      safety_q <= 1'b0;
      safety_output_a <= 1'b0;
      safety_output_b <= 1'b0;
    end else begin
      // Both channels come from the same decision, each its own flop
      safety_output_a <= safety_d;
      safety_output_b <= safety_d;
      safety_q <= safety_d;
    end
  end

  // Previous-cycle copies feed the interrupt edge detectors
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stable_q <= 1'b0;
      muted_q <= 1'b0;
    end else begin
      stable_q <= light_stable & all_clear;
      muted_q <= muted;
    end
  end

  // ****************************************
  // Blink generator
  // ****************************************

  reg [23:0] blink_cnt_q;
  reg blink_q;
  wire blink_wrap;

  // Free-running, so the blink phase does not depend on when a beam appears
  assign blink_wrap = (blink_cnt_q == BLINK_HALF_CYC - 24'h000001);

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      blink_cnt_q <= 24'h000000;
      blink_q <= 1'b0;
    end else if (blink_wrap) begin
      blink_cnt_q <= 24'h000000;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 24'h000001;
    end
  end

  // ****************************************
  // Alignment display
  // ****************************************

  // Red decision per segment, before the green override
  wire [`LCI_NUM_SEG-1:0] seg_red_d;

  genvar g;
  generate
    for (g = 0; g < `LCI_NUM_SEG; g = g + 1) begin : g_seg
      reg red_d;
      always @* begin
        red_d = grp_full(beam_rx, g);
        // End channels blink while their group is only partly lit
        if (g == SEG_TOP) begin
          if (!red_d && beam_rx[CH_TOP]) begin
            red_d = blink_q;
          end
        end
        if (g == SEG_BOT) begin
          if (!red_d && beam_rx[CH_BOT]) begin
            red_d = blink_q;
          end
        end
      end
      assign seg_red_d[g] = red_d;
    end
  endgenerate

  // Both colours come from the same decision, so they never light together
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      beam_alignment_display_green <= {`LCI_NUM_SEG{1'b0}};
      beam_alignment_display_red <= {`LCI_NUM_SEG{1'b0}};
    end else begin
      beam_alignment_display_green <= {`LCI_NUM_SEG{safety_d}};
      beam_alignment_display_red <= seg_red_d & ~{`LCI_NUM_SEG{safety_d}};
    end
  end

  // ****************************************
  // Stability lamp
  // ****************************************

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      light_stability_lamp_green <= 1'b0;
      light_stability_lamp_orange <= 1'b0;
    end else begin
      // A blocked path overrides the stability classification
      light_stability_lamp_green <= all_clear & light_stable;
      light_stability_lamp_orange <= all_clear & ~light_stable;
    end
  end

  // ****************************************
  // Large indicator
  // ****************************************

  // Red and green inputs are independent, so both colours may show at once
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      big_lamp_red <= 1'b0;
      big_lamp_green <= 1'b0;
    end else begin
      big_lamp_red <= big_red_in;
      big_lamp_green <= big_green_in;
    end
  end

  // ****************************************
  // Interrupt events
  // ****************************************

  wire [`LCI_IRQ_W-1:0] irq_ev;
  wire [`LCI_IRQ_W-1:0] irq_clr;

  assign irq_ev[`LCI_IRQ_OFF] = safety_q & ~safety_d;
  assign irq_ev[`LCI_IRQ_ON] = ~safety_q & safety_d;
  assign irq_ev[`LCI_IRQ_UNSTABLE] = stable_q & all_clear & ~light_stable;
  assign irq_ev[`LCI_IRQ_MUTE] = ~muted_q & muted;

  assign irq_clr = wr_hit(wr_commit, wb_adr_i, `LCI_OFS_IRQ_STAT) ?
                   wb_dat_i[`LCI_IRQ_W-1:0] : {`LCI_IRQ_W{1'b0}};

  // ****************************************
  // Interrupt status and request
  // ****************************************

  always @* begin
    // A new event in the clearing cycle is kept
    irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_q <= {`LCI_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq <= |(irq_stat_d & irq_mask_q);
    end
  end

  // ****************************************
  // Wishbone read data
  // ****************************************

  always @* begin
    rd_data_d = 32'h00000000;
    case (wb_adr_i)
      `LCI_OFS_CTRL: begin
        rd_data_d[1:0] = ctrl_q;
      end
      `LCI_OFS_STATUS: begin
        rd_data_d[`LCI_ST_SAFETY_ON] = safety_q;
        rd_data_d[`LCI_ST_ALL_CLEAR] = all_clear;
        rd_data_d[`LCI_ST_MUTED] = muted;
        rd_data_d[`LCI_ST_STABLE] = light_stable & all_clear;
      end
      `LCI_OFS_IRQ_STAT: begin
        rd_data_d[`LCI_IRQ_W-1:0] = irq_stat_q;
      end
      `LCI_OFS_IRQ_MASK: begin
        rd_data_d[`LCI_IRQ_W-1:0] = irq_mask_q;
      end
      `LCI_OFS_BEAMS: begin
        rd_data_d[`LCI_NUM_CH-1:0] = beam_rx;
      end
      default: begin
        rd_data_d = 32'h00000000;
      end
    endcase
  end

  // ****************************************
  // Wishbone handshake
  // ****************************************

  // Zero outside the ack cycle so a stale word is never taken for an answer
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      // Unmapped addresses still answer, reading zero
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req & ~wb_ack_o & ~wb_we_i) begin
        wb_dat_o <= rd_data_d;
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // ****************************************
  // Control and mask registers
  // ****************************************

  // Writes land only on the edge where the master sees ack
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `LCI_CTRL_RST;
      irq_mask_q <= `LCI_IRQ_MASK_RST;
    end else begin
      if (wr_hit(wr_commit, wb_adr_i, `LCI_OFS_CTRL)) begin
        ctrl_q <= wb_dat_i[1:0];
      end
      if (wr_hit(wr_commit, wb_adr_i, `LCI_OFS_IRQ_MASK)) begin
        irq_mask_q <= wb_dat_i[`LCI_IRQ_W-1:0];
      end
    end
  end

endmodule // lci_light_curtain

//--- testbench/lci_checker.sv
// Port-level checks for the light curtain decision and indicator block.
// Assumes binding to lci_light_curtain, everything on ref_clk.
`timescale 1ns/10ps
module lci_checker (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Front end and indicator inputs
  input wire [15:0] beam_rx,
  input wire light_stable,
  input wire muting_active,
  input wire big_red_in,
  input wire big_green_in,
  // Outputs watched
  input wire safety_output_a,
  input wire safety_output_b,
  input wire light_stability_lamp_green,
  input wire light_stability_lamp_orange,
  input wire [3:0] beam_alignment_display_green,
  input wire [3:0] beam_alignment_display_red,
  input wire big_lamp_red,
  input wire big_lamp_green
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire clr;
  assign clr = &beam_rx;
  // Muting is left out so the check holds whatever the control bits are
  sequence s_blocked;
    !clr && !muting_active;
  endsequence
  property p_off; s_blocked |=> !safety_output_a; endproperty
  a_off: assert property (p_off) else $error("outputs on while blocked");
  property p_green; {safety_output_b, beam_alignment_display_green} == {5{safety_output_a}}; endproperty
  a_green: assert property (p_green) else $error("outputs or green segments disagree");
  property p_prio; (beam_alignment_display_green & beam_alignment_display_red) == 4'h0; endproperty
  a_prio: assert property (p_prio) else $error("segment both colours");
  property p_top; s_blocked and (&beam_rx[15:12]) |=> beam_alignment_display_red[3]; endproperty
  a_top: assert property (p_top) else $error("top segment not red");
  property p_bot; s_blocked and (&beam_rx[3:0]) |=> beam_alignment_display_red[0]; endproperty
  a_bot: assert property (p_bot) else $error("bottom segment not red");
  property p_stab; clr && light_stable |=> light_stability_lamp_green && !light_stability_lamp_orange; endproperty
  a_stab: assert property (p_stab) else $error("stable lamp wrong");
  property p_orng; clr && !light_stable |=> light_stability_lamp_orange && !light_stability_lamp_green; endproperty
  a_orng: assert property (p_orng) else $error("unstable lamp wrong");
  property p_dark; !clr |=> !light_stability_lamp_green && !light_stability_lamp_orange; endproperty
  a_dark: assert property (p_dark) else $error("lamp lit while blocked");
  property p_big; 1'b1 |=> {big_lamp_red, big_lamp_green} == $past({big_red_in, big_green_in}); endproperty
  a_big: assert property (p_big) else $error("large lamp wrong");
endmodule // lci_checker

bind lci_light_curtain lci_checker lci_checker_inst (
  .ref_clk(ref_clk), .nrst(nrst), .beam_rx(beam_rx), .light_stable(light_stable),
  .muting_active(muting_active), .big_red_in(big_red_in), .big_green_in(big_green_in),
  .safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
  .light_stability_lamp_green(light_stability_lamp_green),
  .light_stability_lamp_orange(light_stability_lamp_orange),
  .beam_alignment_display_green(beam_alignment_display_green),
  .beam_alignment_display_red(beam_alignment_display_red),
  .big_lamp_red(big_lamp_red), .big_lamp_green(big_lamp_green));

//--- testbench/lci_machine_model.sv
// Machine control side reading the two safety outputs.
// Assumes both outputs wired straight from the block.
`timescale 1ns/10ps
module lci_machine_model (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Safety inputs
  input wire out_a,
  input wire out_b,
  // Machine permitted to run
  output reg run_q
);
  // One channel alone never runs the machine
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      run_q <= 1'b0;
    else
      run_q <= out_a & out_b;
  end
endmodule // lci_machine_model

//--- testbench/tb_top.sv
// Self-checking bench for the light curtain block, with a machine model.
// Assumes a short blink half period of 4 cycles.
`timescale 1ns/10ps
module tb_top;
  reg ref_clk = 1'b0;
  reg nrst = 1'b0;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0, full, on;
  reg [7:0] adr = 8'h00;
  reg [3:0] sel = 4'h0;
  reg [31:0] dat = 32'h0, rd, lfsr = 32'h1229b44e;
  reg [15:0] beams = 16'h0;
  reg [1:0] ctrl = 2'h0;
  reg stab = 1'b0, mute = 1'b0, bred = 1'b0, bgrn = 1'b0;
  wire [31:0] dat_o;
  wire ack, sa, sb, lg, lo, br, bg, irq, run;
  wire [3:0] sg, sr;
  integer fails = 0, n_tests = 0, i, j, k, cnt;
  always #12.5 ref_clk = ~ref_clk;
  lci_light_curtain #(.BLINK_HALF_CYC(24'd4)) lci_light_curtain_inst (.ref_clk(ref_clk), .nrst(nrst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .beam_rx(beams), .light_stable(stab), .muting_active(mute),
    .big_red_in(bred), .big_green_in(bgrn), .safety_output_a(sa), .safety_output_b(sb),
    .light_stability_lamp_green(lg), .light_stability_lamp_orange(lo), .beam_alignment_display_green(sg),
    .beam_alignment_display_red(sr), .big_lamp_red(br), .big_lamp_green(bg), .irq(irq));
  lci_machine_model lci_machine_model_inst (.ref_clk(ref_clk), .nrst(nrst), .out_a(sa), .out_b(sb),
    .run_q(run));
  // ****
  // Helpers
  // ****
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Entered just after a rising edge; leaves one idle cycle behind
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
      k = 0;
      do begin
        @(posedge ref_clk);
        k = k + 1;
      end while (ack !== 1'b1 && k < 20);
      if (k >= 20) begin
        fails = fails + 1;
        finish_test;
      end
      rd = dat_o;
      {cyc, stb} <= 2'b00;
      @(posedge ref_clk);
    end
  endtask
  // x = {mute, stable, red in, green in}; three edges so the machine model settles too
  task step(input [15:0] b, input [3:0] x);
    begin
      {beams, mute, stab, bred, bgrn} <= {b, x};
      repeat (3) @(posedge ref_clk);
      on = !ctrl[1] && (&b || (ctrl[0] && x[3]));
      chk({sa, sb, run}, {3{on}});
      chk(sg, {4{on}});
      for (i = 0; i < 4; i = i + 1) begin
        full = &b[4*i +: 4];
        if (on || full || !((i == 3 && b[15]) || (i == 0 && b[0])))
          chk(sr[i], !on && full);
      end
      chk({lg, lo}, {&b && x[2], &b && !x[2]});
      chk({br, bg}, x[1:0]);
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    for (j = 0; j < 4; j = j + 1) begin
      ctrl = j;
      wb(1'b1, 8'h00, j);
      repeat (12) begin
        lfsr = nxt(lfsr);
        step(lfsr[4] ? 16'hffff : lfsr[31:16] | {{4{lfsr[8]}}, {4{lfsr[7]}}, {4{lfsr[6]}}, {4{lfsr[5]}}},
          lfsr[3:0]);
      end
    end
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, {16'h0, beams});
    ctrl = 2'h0;
    wb(1'b1, 8'h00, 32'h0);
    // Two full blink periods always hold exactly 8 lit cycles
    for (j = 0; j < 2; j = j + 1) begin
      step(j ? 16'h8000 : 16'h0001, 4'h0);
      cnt = 0;
      repeat (16) begin
        @(posedge ref_clk);
        cnt = cnt + (j ? sr[3] : sr[0]);
      end
      chk(cnt, 8);
    end
    wb(1'b1, 8'h0c, 32'hf);
    step(16'hffff, 4'h4);
    // Status: outputs on, all clear, not muted, stable
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'hb);
    wb(1'b1, 8'h08, 32'hf);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    step(16'hfffe, 4'h4);
    chk(irq, 1'b1);
    // Only the outputs-off event is pending
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, 8'h0c, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    finish_test;
  end
endmodule // tb_top
